/* File: logic/pcd_core.sv */
// Pulse count dimming control: enable, 32-level count, gating and shutdown.
//
// Function
// - The first rising edge of the dimming input after shutdown enables the device at full scale 25 mA.
// - Every later qualified rising edge lowers the level by one thirty-second of full scale.
// - After 31 counted pulses the level is lowest and the next edge wraps to full scale.
// - There are exactly 32 levels, chosen only by pulsing the dimming input.
// - The level is the count, modulo 32, of qualified dimming pulses after the enabling edge since power-up or shutdown.
// - The dimming input also acts as enable: activity turns on, long low turns off.
// - While the gate input is high all six channels carry the programmed level.
// - While the gate input is low all channel currents are zero.
// - Either input held low for about 20 ms puts the device into shutdown.
// - The device is always shut down once the dimming input stays low beyond 20 ms.
// - Dimming low pulses shorter than the minimum low time are ignored and not counted.
// - A dimming low period longer than the maximum low time is treated as a shutdown request.
// - Supply undervoltage disables every channel and enters shutdown.
// - In shutdown every channel sink is high impedance with zero current.
`timescale 1ns/1ns
`include "pcd_regs.svh"
module pcd_core #(
  parameter int SHDN_CYC = `PCD_SHDN_LOW_CYC,
  parameter int MAXLO_CYC = `PCD_MAX_LOW_CYC
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      dim_pulse_input_i,
  input  wire logic                      gate_i,
  input  wire logic                      uvlo_i,
  output logic [`PCD_NUM_CHANNELS-1:0]   channel_sink_en_o,
  output logic [`PCD_NUM_CHANNELS-1:0]   channel_sink_oe_o,
  output pcd_pkg::pcd_level_t            level_o,
  output logic                           enabled_o
);
  import pcd_pkg::*;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // A low of exactly the minimum programming time must still count.
  function automatic logic min_low_met(input logic [9:0] cnt);
    return cnt >= 10'(`PCD_MIN_LOW_CYC);
  endfunction : min_low_met

  // Sinks and status follow the next state, so all outputs move on one edge.
  function automatic logic state_on(input pcd_state_t st);
    return st == PCD_ACTIVE;
  endfunction : state_on

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  logic [1:0] dim_s_q;
  logic [1:0] gate_s_q;
  logic [1:0] uv_s_q;
  logic       dim_prev_q;
  // Reset values match the pulled-down idle level of the pins, so no false edge follows reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dim_s_q    <= 2'h0;
      gate_s_q   <= 2'h0;
      uv_s_q     <= 2'h0;
      dim_prev_q <= 1'b0;
    end else begin
      dim_s_q    <= {dim_s_q[0], dim_pulse_input_i};
      gate_s_q   <= {gate_s_q[0], gate_i};
      uv_s_q     <= {uv_s_q[0], uvlo_i};
      dim_prev_q <= dim_s_q[1];
    end
  end

  wire dim_lvl  = dim_s_q[1];
  wire gate_lvl = gate_s_q[1];
  wire uv_lvl   = uv_s_q[1];

  // -------------------------------------------------------------------------
  // Low-time measurement
  // -------------------------------------------------------------------------
  logic [9:0] low_cnt_q;
  logic [9:0] low_cnt_d;
  logic       short_ok;
  always_comb begin
    low_cnt_d = low_cnt_q;
    if (dim_lvl) begin
      low_cnt_d = 10'h000;
    end else if (!min_low_met(low_cnt_q)) begin
      low_cnt_d = low_cnt_q + 10'h001;
    end
  end
  // Looking at the next count lets the last low cycle qualify the pulse.
  assign short_ok = min_low_met(low_cnt_d);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_q <= 10'h000;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  logic dim_long;
  logic dim_shdn;
  logic gate_shdn;
  // All three timers saturate; a dimming pin held low keeps the device shut down, but with the gate held low each dimming edge enables it for one cycle.
  // long low as shutdown
  pcd_low_timer #(.CNT_W(`PCD_TIMER_CNT_W), .LIMIT(MAXLO_CYC)) u_dim_max (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .level_i   (dim_lvl),
    .expired_o (dim_long)
  );
  pcd_low_timer #(.CNT_W(`PCD_TIMER_CNT_W), .LIMIT(SHDN_CYC)) u_dim_shdn (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .level_i   (dim_lvl),
    .expired_o (dim_shdn)
  );
  pcd_low_timer #(.CNT_W(`PCD_TIMER_CNT_W), .LIMIT(SHDN_CYC)) u_gate_shdn (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .level_i   (gate_lvl),
    .expired_o (gate_shdn)
  );

  // -------------------------------------------------------------------------
  // Enable state and pulse count
  // -------------------------------------------------------------------------
  pcd_state_t state_q;
  pcd_state_t state_d;
  pcd_level_t cnt_q;
  pcd_level_t cnt_d;
  logic       rise;
  logic       dim_held_q;
  logic       dim_held_d;
  assign rise = dim_lvl && !dim_prev_q;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    dim_held_d = dim_held_q;
    if (dim_lvl) begin
      dim_held_d = 1'b0;
    end else if (short_ok) begin
      dim_held_d = 1'b1;
    end
    case (state_q)
      PCD_SHUTDOWN: begin
        cnt_d = `PCD_CNT_RESET;
        // first edge enables at full scale
        // activity enables
        // Undervoltage blocks the enabling edge, so a sagging supply cannot restart the sinks.
        if (rise && !uv_lvl) begin
          state_d = PCD_ACTIVE;
        end
      end
      PCD_ACTIVE: begin
        if (uv_lvl || dim_long || dim_shdn || gate_shdn) begin
          state_d = PCD_SHUTDOWN;
          cnt_d   = `PCD_CNT_RESET;
        end else if (rise && dim_held_q) begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      default: begin
        state_d = PCD_SHUTDOWN;
        cnt_d   = `PCD_CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= PCD_SHUTDOWN;
      cnt_q      <= `PCD_CNT_RESET;
      dim_held_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      dim_held_q <= dim_held_d;
    end
  end

  // -------------------------------------------------------------------------
  // Channel drive
  // -------------------------------------------------------------------------
  logic [`PCD_NUM_CHANNELS-1:0] en_d;
  logic [`PCD_NUM_CHANNELS-1:0] oe_d;
  // Registered so the sinks never see a combinational glitch on the gate.
  always_comb begin
    en_d = '0;
    oe_d = '0;
    if (state_on(state_d)) begin
      oe_d = '1;
      if (gate_lvl) begin
        en_d = '1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      channel_sink_en_o <= '0;
      channel_sink_oe_o <= '0;
      level_o           <= `PCD_CNT_RESET;
      enabled_o         <= 1'b0;
    end else begin
      channel_sink_en_o <= en_d;
      channel_sink_oe_o <= oe_d;
      level_o           <= cnt_d;
      enabled_o         <= state_on(state_d);
    end
  end
endmodule : pcd_core

/* File: logic/pcd_regs.svh */
// Timing and level constants for the pulse count dimming control.
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH
// ---------------------------------------------------------------------------
// Clock and times
// ---------------------------------------------------------------------------
`define PCD_CLK_PERIOD_NS     10
`define PCD_MIN_LOW_NS        200
`define PCD_MAX_LOW_NS        100000
`define PCD_SHDN_LOW_MS       20
`define PCD_SHDN_LOW_NS       (`PCD_SHDN_LOW_MS * 1000000)
`define PCD_MIN_LOW_CYC       ((`PCD_MIN_LOW_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_MAX_LOW_CYC       (`PCD_MAX_LOW_NS / `PCD_CLK_PERIOD_NS)
`define PCD_SHDN_LOW_CYC      (`PCD_SHDN_LOW_NS / `PCD_CLK_PERIOD_NS)
`define PCD_TIMER_CNT_W       25
// ---------------------------------------------------------------------------
// Levels
// ---------------------------------------------------------------------------
`define PCD_NUM_LEVELS        32
`define PCD_FULL_SCALE_UA     25000
`define PCD_NUM_CHANNELS      6
`define PCD_CNT_RESET         5'h00
`endif

/* File: logic/pcd_pkg.sv */
// Types shared by the pulse count dimming control.
package pcd_pkg;
  typedef enum logic [1:0] {
    PCD_SHUTDOWN,
    PCD_ACTIVE
  } pcd_state_t;
  typedef logic [4:0] pcd_level_t;
endpackage : pcd_pkg

/* File: logic/pcd_low_timer.sv */
// Low-time counter for one synchronised input.
`timescale 1ns/1ns
module pcd_low_timer #(
  parameter int CNT_W   = 25,
  parameter int LIMIT   = 2000000
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      expired_o
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             exp_q;
  logic             exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (level_i) begin
      cnt_d = '0;
    end else if (cnt_q >= CNT_W'(LIMIT)) begin
      exp_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;
endmodule : pcd_low_timer

/* File: verification/pcd_core_props.sv */
// Port checker for the pulse count dimming control.
`timescale 1ns/1ns
`include "pcd_regs.svh"
module pcd_core_props #(
  parameter int SHDN_CYC  = 200,
  parameter int MAXLO_CYC = 100
) (
  input wire logic                        clk_sys_i,
  input wire logic                        rst_i,
  input wire logic                        dim_pulse_input_i,
  input wire logic                        gate_i,
  input wire logic                        uvlo_i,
  input wire logic [`PCD_NUM_CHANNELS-1:0] channel_sink_en_o,
  input wire logic [`PCD_NUM_CHANNELS-1:0] channel_sink_oe_o,
  input wire pcd_pkg::pcd_level_t         level_o,
  input wire logic                        enabled_o
);
  import pcd_pkg::*;
  int lo_q;
  int gl_q;
  // Slack of eight cycles covers the input synchronisers and output register.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lo_q <= 0;
      gl_q <= 0;
    end else begin
      lo_q <= dim_pulse_input_i ? 0 : lo_q + 1;
      gl_q <= gate_i ? 0 : gl_q + 1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_off_no_drive: assert property (!enabled_o |-> channel_sink_oe_o == 6'h00 && channel_sink_en_o == 6'h00)
    else $error("sinks driven while off");
  a_on_all_drive: assert property (enabled_o |-> channel_sink_oe_o == 6'h3F)
    else $error("sinks not driven while on");
  a_gate_zero: assert property ((!gate_i) [*5] |-> channel_sink_en_o == 6'h00)
    else $error("current with gate low");
  a_gate_conduct: assert property ((gate_i && enabled_o) [*5] |-> channel_sink_en_o == 6'h3F)
    else $error("no current with gate high");
  a_uvlo_off: assert property (uvlo_i [*6] |-> !enabled_o)
    else $error("on during undervoltage");
  a_enable_full: assert property ($rose(enabled_o) |-> level_o == 5'h00)
    else $error("enable not at full scale");
  a_level_step: assert property (enabled_o && $past(enabled_o) && $changed(level_o) |-> level_o == $past(level_o) + 5'h01)
    else $error("level step wrong");
  a_level_cause: assert property (enabled_o && $changed(level_o) |-> $past(dim_pulse_input_i, 3))
    else $error("level moved without pulse");
  a_dim_low_off: assert property (lo_q > MAXLO_CYC + 8 |-> !enabled_o)
    else $error("long dim low kept on");
  a_gate_low_off: assert property (gl_q > SHDN_CYC + 8 |-> !enabled_o)
    else $error("long gate low kept on");
endmodule : pcd_core_props
bind pcd_core pcd_core_props #(.SHDN_CYC(SHDN_CYC), .MAXLO_CYC(MAXLO_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .dim_pulse_input_i(dim_pulse_input_i), .gate_i(gate_i),
  .uvlo_i(uvlo_i), .channel_sink_en_o(channel_sink_en_o), .channel_sink_oe_o(channel_sink_oe_o),
  .level_o(level_o), .enabled_o(enabled_o));

/* File: verification/pcd_host_model.sv */
// Host model that drives the dimming and gating pins.
`timescale 1ns/1ns
module pcd_host_model (
  input  wire logic clk_sys_i,
  output logic      dim_o,
  output logic      gate_o
);
  initial begin
    dim_o = 1'b0;
    gate_o = 1'b1;
  end
  // Called at a falling edge; holds low then high for whole cycles.
  task automatic pulse(input int lo, input int hi);
    dim_o = 1'b0;
    repeat (lo) @(negedge clk_sys_i);
    dim_o = 1'b1;
    repeat (hi) @(negedge clk_sys_i);
  endtask : pulse
  task automatic gate_low(input int n);
    gate_o = 1'b0;
    repeat (n) @(negedge clk_sys_i);
    gate_o = 1'b1;
  endtask : gate_low
endmodule : pcd_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the pulse count dimming control.
`timescale 1ns/1ns
module tb_top;
  import pcd_pkg::*;
  logic       clk_sys_i, rst_i, uvlo_i, dim, gate, enabled_o;
  logic [5:0] en_o, oe_o, last;
  pcd_level_t level_o;
  logic [5:0] exp_q[$];
  int         n_mismatch, compares, seed, i;
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  pcd_host_model host (.clk_sys_i(clk_sys_i), .dim_o(dim), .gate_o(gate));
  // Short counts keep the shutdown scenarios quick.
  pcd_core #(.SHDN_CYC(200), .MAXLO_CYC(100)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .dim_pulse_input_i(dim), .gate_i(gate), .uvlo_i(uvlo_i), .channel_sink_en_o(en_o),
    .channel_sink_oe_o(oe_o), .level_o(level_o), .enabled_o(enabled_o));
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // An unannounced change is compared with the old value, so it always counts.
  always @(posedge clk_sys_i) begin
    if (!rst_i && {enabled_o, level_o} !== last) begin
      if (exp_q.size() == 0) chk({enabled_o, level_o}, last);
      else chk({enabled_o, level_o}, exp_q.pop_front());
      last = {enabled_o, level_o};
    end
  end
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    seed = 32'hf20c0257;
    last = 6'h00;
    rst_i = 1'b1;
    uvlo_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    exp_q.push_back(6'h20);
    host.pulse(30, 10);
    for (i = 1; i <= 33; i++) begin
      exp_q.push_back({1'b1, 5'(i)});
      // Gate low never spans two pulses, so it stays well short of the shutdown time.
      host.gate_o = (i % 2 == 1) ? 1'b1 : 1'($random(seed));
      host.pulse((i == 1) ? 20 : 20 + ($unsigned($random(seed)) % 71), 10);
    end
    host.gate_o = 1'b1;
    host.pulse(19, 10);
    host.gate_o = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk(en_o, 6'h00);
    host.gate_o = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    chk(en_o, 6'h3F);
    // A reset in mid-run, with the dimming pin low, restarts the count at full scale.
    exp_q.push_back(6'h00);
    exp_q.push_back(6'h20);
    fork
      host.pulse(40, 10);
      begin
        repeat (5) @(negedge clk_sys_i);
        rst_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk(oe_o, 6'h00);
        rst_i = 1'b0;
      end
    join
    exp_q.push_back(6'h00);
    exp_q.push_back(6'h20);
    exp_q.push_back(6'h21);
    host.pulse(120, 10);
    host.pulse(30, 10);
    exp_q.push_back(6'h00);
    host.gate_low(230);
    chk(oe_o, 6'h00);
    exp_q.push_back(6'h20);
    host.pulse(30, 10);
    uvlo_i = 1'b1;
    exp_q.push_back(6'h00);
    repeat (6) @(negedge clk_sys_i);
    // Once shut down, supply glitches must not restart the sinks without a dimming edge.
    repeat (8) begin
      uvlo_i = 1'($random(seed));
      @(negedge clk_sys_i);
    end
    uvlo_i = 1'b1;
    host.pulse(30, 10);
    uvlo_i = 1'b0;
    exp_q.push_back(6'h20);
    host.pulse(30, 10);
    chk(6'(exp_q.size()), 6'h00);
    finish_test();
  end
endmodule : tb_top
